//--- psm_pkg.sv
// Constants, mode codes and decode helpers for the power stage control logic.
// Assumes a single 125 MHz clock domain and an AHB-Lite register port.
`default_nettype none

package psm_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int FILTER_NS = 32;
    // Least time, rounded up to whole cycles
    localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT_CNT_W = 3;
    localparam logic [FLT_CNT_W-1:0] FLT_LAST = FLT_CNT_W'(FILTER_CYCLES - 1);
    localparam logic [31:0] RAMP_CYCLES_RST = 32'h0000_1000;

    // ****************************************
    // Channels and fault inputs
    // ****************************************
    localparam int NUM_CH = 4;
    localparam int NUM_PAIR = 2;
    localparam int CH_PER_PAIR = 2;
    localparam int FLT_OC0 = 0;
    localparam int FLT_TW = 4;
    localparam int FLT_TE = 5;
    localparam int FLT_UV = 6;
    localparam int NUM_FLT = 7;

    // ****************************************
    // Output mode codes
    // ****************************************
    localparam logic [2:0] MODE_STEREO_FB = 3'h0;
    localparam logic [2:0] MODE_MIXED = 3'h1;
    localparam logic [2:0] MODE_MONO_PAR = 3'h2;
    localparam logic [2:0] MODE_QUAD_HB = 3'h3;
    localparam logic [2:0] MODE_STEREO_INV = 3'h4;
    localparam logic [2:0] MODE_MIXED_INV = 3'h5;
    localparam logic [2:0] MODE_MONO_INV = 3'h6;
    localparam logic [2:0] MODE_RESERVED = 3'h7;

    localparam logic [3:0] INV_NONE = 4'h0;
    localparam logic [3:0] INV_STEREO = 4'ha;
    localparam logic [3:0] INV_MIXED = 4'h8;
    localparam logic [3:0] INV_MONO = 4'hc;
    localparam logic [3:0] RAMP_ALL = 4'hf;
    localparam logic [3:0] RAMP_HALF_ONLY = 4'h3;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RAMP = 8'h04;
    localparam int STATUS_PAD_W = 14;

    typedef enum logic [1:0] {PS_IDLE, PS_RAMP, PS_RUN} psm_pair_state_t;

    function automatic logic is_mixed(input logic [2:0] m);
        return (m == MODE_MIXED) || (m == MODE_MIXED_INV);
    endfunction

    function automatic logic [3:0] inv_mask(input logic [2:0] m);
        return (m == MODE_STEREO_INV) ? INV_STEREO :
               (m == MODE_MIXED_INV) ? INV_MIXED :
               (m == MODE_MONO_INV) ? INV_MONO : INV_NONE;
    endfunction

    function automatic logic [3:0] ramp_mask(input logic [2:0] m);
        return is_mixed(m) ? RAMP_HALF_ONLY : RAMP_ALL;
    endfunction

endpackage

`default_nettype wire

//--- psm_stage.sv
// Mode routing, start-up gating and fault latching of a four-channel power stage.
// Assumes pins arrive asynchronously and a single AHB-Lite master on hclk.
//
// Summary of operation
// - Outputs follow inputs, inverted only per mode
// - Mode 000: no inversion, modulator inverts
// - Mode 010: no inversion, parallel wiring
// - Mode 011: four independent uninverted channels
// - Mode 100: inputs two, four inverted
// - Mode 110: inputs three, four inverted
// - Modes 001/101: input four inverted in 101
// - Mixed modes ramp only outputs one, two
// - Mixed modes never ramp outputs three, four
// - Errors shut down; warning alone does not
// - Flags are active-low open-drain drivers
// - Over-current reported per channel pair
// - Over-current holds pair off until reset toggle
// - Warning flag low while too hot
// - Thermal error pulls error flag low
// - Supply under-voltage pulls error flag low
// - Thermal or supply error stops all; both resets
// - Two flags encode warning and error status
// - Pair reset low clears state, outputs off
// - Output waits for own input rising edge
// - Ramp to bias before switching when enabled
`default_nettype none

module psm_stage (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite register port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Modulator and configuration pins
    input wire logic [3:0] pwm_input,
    input wire logic [2:0] output_mode_select,
    input wire logic reset_pair_a_n,
    input wire logic reset_pair_b_n,
    input wire logic ramp_enable,
    // Analog comparator levels
    input wire logic [3:0] overcurrent_detect,
    input wire logic thermal_warning_detect,
    input wire logic thermal_error_detect,
    input wire logic high_voltage_supply_low,
    // Power output drivers
    output logic [3:0] power_output,
    output logic [3:0] power_output_oe,
    output logic [3:0] ramp_active,
    // Open-drain flags
    input wire logic overcurrent_flag_a_n_i,
    output logic overcurrent_flag_a_n_o,
    output logic overcurrent_flag_a_n_oe,
    input wire logic overcurrent_flag_b_n_i,
    output logic overcurrent_flag_b_n_o,
    output logic overcurrent_flag_b_n_oe,
    input wire logic thermal_undervolt_error_n_i,
    output logic thermal_undervolt_error_n_o,
    output logic thermal_undervolt_error_n_oe,
    input wire logic thermal_warning_n_i,
    output logic thermal_warning_n_o,
    output logic thermal_warning_n_oe
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [3:0] pwm_m, pwm_s, pwm_d;
    logic [2:0] mode_m, mode_s;
    logic [1:0] rst_m, rst_s, rst_d;
    logic ramp_m, ramp_s;
    logic [psm_pkg::NUM_FLT-1:0] flt_m, flt_s, flt_f;
    logic [3:0] pin_m, pin_s;
    logic [psm_pkg::FLT_CNT_W-1:0] flt_cnt [psm_pkg::NUM_FLT];

    wire [psm_pkg::NUM_FLT-1:0] flt_raw = {high_voltage_supply_low, thermal_error_detect,
                                           thermal_warning_detect, overcurrent_detect};
    wire [3:0] pin_raw = {thermal_warning_n_i, thermal_undervolt_error_n_i,
                          overcurrent_flag_b_n_i, overcurrent_flag_a_n_i};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_m <= 4'h0;
            pwm_s <= 4'h0;
            pwm_d <= 4'h0;
            mode_m <= 3'h0;
            mode_s <= 3'h0;
            rst_m <= 2'h0;
            rst_s <= 2'h0;
            rst_d <= 2'h0;
            ramp_m <= 1'b0;
            ramp_s <= 1'b0;
            flt_m <= 7'h00;
            flt_s <= 7'h00;
            pin_m <= 4'hf;
            pin_s <= 4'hf;
        end else begin
            pwm_m <= pwm_input;
            pwm_s <= pwm_m;
            pwm_d <= pwm_s;
            mode_m <= output_mode_select;
            mode_s <= mode_m;
            rst_m <= {reset_pair_b_n, reset_pair_a_n};
            rst_s <= rst_m;
            rst_d <= rst_s;
            ramp_m <= ramp_enable;
            ramp_s <= ramp_m;
            flt_m <= flt_raw;
            flt_s <= flt_m;
            pin_m <= pin_raw;
            pin_s <= pin_m;
        end
    end

    // ****************************************
    // Glitch filter on comparator levels
    // ****************************************
    // A level must differ from the filtered value for the whole window before it is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flt_f <= 7'h00;
            for (int i = 0; i < psm_pkg::NUM_FLT; i++) begin
                flt_cnt[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < psm_pkg::NUM_FLT; i++) begin
                if (flt_s[i] == flt_f[i]) begin
                    flt_cnt[i] <= 3'h0;
                end else if (flt_cnt[i] == psm_pkg::FLT_LAST) begin
                    flt_f[i] <= flt_s[i];
                    flt_cnt[i] <= 3'h0;
                end else begin
                    flt_cnt[i] <= flt_cnt[i] + 3'h1;
                end
            end
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    wire [1:0] rst_rise = rst_s & ~rst_d;
    wire [3:0] pwm_rise = pwm_s & ~pwm_d;
    wire [3:0] inv_now = psm_pkg::inv_mask(mode_s);
    wire [3:0] ramp_now = psm_pkg::ramp_mask(mode_s);
    wire mode_bad = (mode_s == psm_pkg::MODE_RESERVED);
    wire sys_fault = flt_f[psm_pkg::FLT_TE] | flt_f[psm_pkg::FLT_UV];
    wire [1:0] oc_pair = {flt_f[psm_pkg::FLT_OC0+3] | flt_f[psm_pkg::FLT_OC0+2],
                          flt_f[psm_pkg::FLT_OC0+1] | flt_f[psm_pkg::FLT_OC0]};

    logic [1:0] oc_lat;
    logic [1:0] sys_lat;
    logic [3:0] armed;
    logic [3:0] run_en;
    logic [31:0] ramp_cycles;
    logic [31:0] ramp_cnt [psm_pkg::NUM_PAIR];
    psm_pkg::psm_pair_state_t pair_st [psm_pkg::NUM_PAIR];

    // ****************************************
    // Fault latches
    // ****************************************
    // Set wins over clear, so a reset rise during a live fault leaves the latch set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_lat <= 2'h0;
            sys_lat <= 2'h0;
        end else begin
            for (int p = 0; p < psm_pkg::NUM_PAIR; p++) begin
                if (oc_pair[p]) begin
                    oc_lat[p] <= 1'b1;
                end else if (rst_rise[p]) begin
                    oc_lat[p] <= 1'b0;
                end
                if (sys_fault) begin
                    sys_lat[p] <= 1'b1;
                end else if (rst_rise[p]) begin
                    sys_lat[p] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Pair sequencing: reset, ramp, run
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < psm_pkg::NUM_PAIR; p++) begin
                pair_st[p] <= psm_pkg::PS_IDLE;
                ramp_cnt[p] <= 32'h0000_0000;
            end
        end else begin
            for (int p = 0; p < psm_pkg::NUM_PAIR; p++) begin
                if (!rst_s[p]) begin
                    pair_st[p] <= psm_pkg::PS_IDLE;
                    ramp_cnt[p] <= 32'h0000_0000;
                end else begin
                    unique case (pair_st[p])
                        psm_pkg::PS_IDLE: begin
                            if (ramp_s && (|ramp_now[p*psm_pkg::CH_PER_PAIR +: 2])) begin
                                pair_st[p] <= psm_pkg::PS_RAMP;
                            end else begin
                                pair_st[p] <= psm_pkg::PS_RUN;
                            end
                        end
                        psm_pkg::PS_RAMP: begin
                            if (ramp_cnt[p] + 32'h0000_0001 >= ramp_cycles) begin
                                pair_st[p] <= psm_pkg::PS_RUN;
                            end else begin
                                ramp_cnt[p] <= ramp_cnt[p] + 32'h0000_0001;
                            end
                        end
                        psm_pkg::PS_RUN: begin
                            pair_st[p] <= psm_pkg::PS_RUN;
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************
    // Channel gating and output drive
    // ****************************************
    always_comb begin
        for (int i = 0; i < psm_pkg::NUM_CH; i++) begin
            run_en[i] = (pair_st[i/psm_pkg::CH_PER_PAIR] == psm_pkg::PS_RUN) && armed[i]
                && !oc_lat[i/psm_pkg::CH_PER_PAIR] && !oc_pair[i/psm_pkg::CH_PER_PAIR]
                && !(|sys_lat) && !sys_fault && !mode_bad;
        end
    end

    // An edge seen during the ramp is kept, so switching starts as soon as the ramp ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed <= 4'h0;
            power_output <= 4'h0;
            power_output_oe <= 4'h0;
            ramp_active <= 4'h0;
        end else begin
            for (int i = 0; i < psm_pkg::NUM_CH; i++) begin
                if (!rst_s[i/psm_pkg::CH_PER_PAIR]) begin
                    armed[i] <= 1'b0;
                end else if (pwm_rise[i]) begin
                    armed[i] <= 1'b1;
                end
                ramp_active[i] <= (pair_st[i/psm_pkg::CH_PER_PAIR] == psm_pkg::PS_RAMP)
                    && ramp_now[i];
            end
            power_output_oe <= run_en;
            power_output <= run_en & (pwm_s ^ inv_now);
        end
    end

    // ****************************************
    // Open-drain flags
    // ****************************************
    // Driver only ever pulls low; the pull-up makes the high level
    assign overcurrent_flag_a_n_o = 1'b0;
    assign overcurrent_flag_b_n_o = 1'b0;
    assign thermal_undervolt_error_n_o = 1'b0;
    assign thermal_warning_n_o = 1'b0;
    assign overcurrent_flag_a_n_oe = oc_lat[0];
    assign overcurrent_flag_b_n_oe = oc_lat[1];
    assign thermal_undervolt_error_n_oe = |sys_lat;
    assign thermal_warning_n_oe = flt_f[psm_pkg::FLT_TW];

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic wr_pend;
    logic [psm_pkg::ADDR_W-1:0] wr_addr;

    wire a_phase = hsel && hready && htrans[1];
    wire [psm_pkg::ADDR_W-1:0] a_addr = haddr[psm_pkg::ADDR_W-1:0];
    wire [1:0] ramping = {pair_st[1] == psm_pkg::PS_RAMP, pair_st[0] == psm_pkg::PS_RAMP};
    wire [31:0] status_word = {{psm_pkg::STATUS_PAD_W{1'b0}}, ramping, mode_s, pin_s,
                               flt_f[psm_pkg::FLT_TW], sys_lat, oc_lat, power_output_oe};
    wire [31:0] rd_val = (a_addr == psm_pkg::ADDR_STATUS) ? status_word :
                         (a_addr == psm_pkg::ADDR_RAMP) ? ramp_cycles : 32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            ramp_cycles <= psm_pkg::RAMP_CYCLES_RST;
        end else begin
            wr_pend <= a_phase && hwrite;
            wr_addr <= a_addr;
            if (a_phase && !hwrite) begin
                hrdata <= rd_val;
            end
            if (wr_pend && (wr_addr == psm_pkg::ADDR_RAMP)) begin
                ramp_cycles <= hwdata;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_first_follow: assert property (
        run_en[0] |=> power_output[0] == $past(pwm_s[0]))
        else $error("Channel one does not follow its input");

    chk_stereo_invert: assert property (
        (mode_s == psm_pkg::MODE_STEREO_INV && run_en[1]) |=> power_output[1] == !$past(pwm_s[1]))
        else $error("Channel two not inverted in stereo inversion mode");

    chk_mono_invert: assert property (
        (mode_s == psm_pkg::MODE_MONO_INV && run_en[2]) |=> power_output[2] == !$past(pwm_s[2]))
        else $error("Channel three not inverted in mono inversion mode");

    chk_mixed_noramp: assert property (
        psm_pkg::is_mixed(mode_s) |=> ramp_active[3:2] == 2'h0)
        else $error("Full-bridge channel ramps in mixed mode");

    chk_ramp_offline: assert property (
        ramp_active[0] |-> !power_output_oe[0])
        else $error("Output switching during ramp");

    chk_reset_hiz: assert property (
        !rst_s[0] |=> !armed[0] ##1 power_output_oe[1:0] == 2'h0)
        else $error("Pair held in reset still drives");

    chk_edge_wait: assert property (
        (rst_s[0] && !armed[0] && !pwm_rise[0]) |=> !power_output_oe[0] ##0 !armed[0])
        else $error("Output enabled before input rising edge");

    chk_oc_shutdown: assert property (
        oc_pair[1] |=> overcurrent_flag_b_n_oe && power_output_oe[3:2] == 2'h0)
        else $error("Over-current on pair b not reported or not shut down");

    chk_sys_shutdown: assert property (
        sys_fault |=> thermal_undervolt_error_n_oe && power_output_oe == 4'h0)
        else $error("Thermal or supply error did not stop all outputs");

    chk_latch_hold: assert property (
        (sys_lat[0] && !rst_rise[0]) |=> sys_lat[0])
        else $error("Shutdown latch cleared without reset rise");

    chk_warn_only: assert property (
        (flt_f[psm_pkg::FLT_TW] && flt_s[psm_pkg::FLT_TW] && !sys_fault && sys_lat == 2'h0)
            |=> thermal_warning_n_oe && !thermal_undervolt_error_n_oe)
        else $error("Thermal warning alone raised the error flag");

endmodule

`default_nettype wire

//--- psm_modulator.sv
// Far-side model: modulator wiring of the four inputs per mode, and the
// pull-ups on the open-drain flag pins.
// Assumes the bench changes mode only while both pair resets are low.
`default_nettype none

module psm_modulator (
    // Configuration and channel data
    input wire logic [2:0] mode,
    input wire logic [3:0] data,
    // Flag drivers of the stage
    input wire logic [3:0] flag_o,
    input wire logic [3:0] flag_oe,
    // Pins
    output logic [3:0] pwm,
    output logic [3:0] flag_lvl
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Input wiring per mode
    // ****************************************
    always_comb begin
        case (mode)
            3'h0: pwm = {~data[2], data[2], ~data[0], data[0]};
            3'h1: pwm = {~data[2], data[2], data[1], data[0]};
            3'h2: pwm = {~data[0], ~data[0], data[0], data[0]};
            3'h3: pwm = data;
            3'h4: pwm = {data[2], data[2], data[0], data[0]};
            3'h5: pwm = {data[2], data[2], data[1], data[0]};
            3'h6: pwm = {4{data[0]}};
            // Reserved mode has no wiring, so every input stays low
            default: pwm = 4'h0;
        endcase
    end

    // Released flag reads high through its pull-up
    assign flag_lvl = (flag_oe & flag_o) | ~flag_oe;

endmodule

`default_nettype wire

//--- tb_top.sv
// Self-checking bench of the power stage control logic.
// Assumes the far-side model in psm_modulator and a 125 MHz hclk.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic rst_a_n, rst_b_n, ramp_en, tw_det, te_det, uv_det;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [1:0] htrans;
    logic [2:0] mode, hsize;
    logic [3:0] data, ocd, pwm, fl, fl_o, fl_oe, pout, poe, pramp;
    int n_fail, n_checks;

    psm_stage u_psm_stage (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pwm_input(pwm), .output_mode_select(mode), .reset_pair_a_n(rst_a_n),
        .reset_pair_b_n(rst_b_n), .ramp_enable(ramp_en), .overcurrent_detect(ocd),
        .thermal_warning_detect(tw_det), .thermal_error_detect(te_det),
        .high_voltage_supply_low(uv_det), .power_output(pout), .power_output_oe(poe),
        .ramp_active(pramp),
        .overcurrent_flag_a_n_i(fl[0]), .overcurrent_flag_a_n_o(fl_o[0]),
        .overcurrent_flag_a_n_oe(fl_oe[0]), .overcurrent_flag_b_n_i(fl[1]),
        .overcurrent_flag_b_n_o(fl_o[1]), .overcurrent_flag_b_n_oe(fl_oe[1]),
        .thermal_undervolt_error_n_i(fl[2]), .thermal_undervolt_error_n_o(fl_o[2]),
        .thermal_undervolt_error_n_oe(fl_oe[2]), .thermal_warning_n_i(fl[3]),
        .thermal_warning_n_o(fl_o[3]), .thermal_warning_n_oe(fl_oe[3])
    );

    psm_modulator u_psm_modulator (
        .mode(mode), .data(data), .flag_o(fl_o), .flag_oe(fl_oe), .pwm(pwm), .flag_lvl(fl)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [3:0] exp_out(input logic [2:0] m, input logic [3:0] p);
        case (m)
            3'h4: return p ^ 4'ha;
            3'h5: return p ^ 4'h8;
            3'h6: return p ^ 4'hc;
            3'h7: return 4'h0;
            default: return p;
        endcase
    endfunction

    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask

    // Every input line sees a low-to-high edge in every mode except reserved mode 111, whose inputs stay low
    task automatic arm();
        data <= 4'h0;
        cyc(4);
        data <= 4'hf;
        cyc(4);
        data <= 4'h0;
        cyc(6);
    endtask

    task automatic pair_cycle(input logic a, input logic b);
        if (a) rst_a_n <= 1'b0;
        if (b) rst_b_n <= 1'b0;
        cyc(5);
        chk(32'(poe & {{2{b}}, {2{a}}}), 32'h0);
        rst_a_n <= 1'b1;
        rst_b_n <= 1'b1;
        cyc(4);
        chk(32'(poe & {{2{b}}, {2{a}}}), 32'h0);
        arm();
    endtask

    task automatic run_mode(input logic [2:0] m, input logic r);
        rst_a_n <= 1'b0;
        rst_b_n <= 1'b0;
        cyc(3);
        mode <= m;
        ramp_en <= r;
        cyc(3);
        rst_a_n <= 1'b1;
        rst_b_n <= 1'b1;
        cyc(5);
        if (r && m != 3'h7) chk(32'(pramp), (m == 3'h1 || m == 3'h5) ? 32'h3 : 32'hf);
        if (!r) chk(32'(poe), 32'h0);
        arm();
        chk(32'(poe), (m == 3'h7) ? 32'h0 : 32'hf);
        repeat (6) begin
            data <= 4'(xs());
            cyc(5);
            chk(32'(pout), 32'(exp_out(m, pwm)));
        end
    endtask

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        cyc(20000);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {hresetn, hsel, hwrite, rst_a_n, rst_b_n, ramp_en, tw_det, te_det, uv_det} = '0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'h0;
        hsize = 3'h2;
        mode = 3'h0;
        data = 4'h0;
        ocd = 4'h0;
        seed = 32'hb487_8434;
        n_fail = 0;
        n_checks = 0;
        cyc(20);
        hresetn <= 1'b1;
        cyc(4);
        ahb(1'b0, 32'(psm_pkg::ADDR_RAMP), 32'h0, rd);
        chk(rd, psm_pkg::RAMP_CYCLES_RST);
        chk(32'(hresp), 32'h0000_0000);
        ahb(1'b0, 32'(psm_pkg::ADDR_STATUS), 32'h0, rd);
        chk(rd, 32'h0000_1e00);
        ahb(1'b1, 32'h0000_0008, xs(), rd);
        ahb(1'b0, 32'h0000_0008, 32'h0, rd);
        chk(rd, 32'h0000_0000);
        // Short ramp keeps each mode pass brief
        ahb(1'b1, 32'(psm_pkg::ADDR_RAMP), 32'h0000_0008, rd);
        ahb(1'b0, 32'(psm_pkg::ADDR_RAMP), 32'h0, rd);
        chk(rd, 32'h0000_0008);
        for (int m = 0; m < 8; m++) run_mode(3'(m), m[0]);
        run_mode(3'h3, 1'b0);
        ocd <= 4'h1;
        cyc(2);
        ocd <= 4'h0;
        cyc(12);
        chk(32'({poe, fl}), 32'hff);
        for (int c = 0; c < 4; c++) begin
            ocd <= 4'(1 << c);
            cyc(12);
            chk(32'({poe, fl}), (c < 2) ? 32'hce : 32'h3d);
            ocd <= 4'h0;
            cyc(12);
            chk(32'({poe, fl}), (c < 2) ? 32'hce : 32'h3d);
            pair_cycle(c < 2, c >= 2);
            chk(32'({poe, fl}), 32'hff);
        end
        tw_det <= 1'b1;
        cyc(12);
        chk(32'({poe, fl}), 32'hf7);
        te_det <= 1'b1;
        cyc(12);
        chk(32'({poe, fl}), 32'h03);
        te_det <= 1'b0;
        tw_det <= 1'b0;
        cyc(12);
        chk(32'(fl), 32'hb);
        pair_cycle(1'b1, 1'b0);
        chk(32'(fl), 32'hb);
        pair_cycle(1'b0, 1'b1);
        chk(32'({poe, fl}), 32'hff);
        uv_det <= 1'b1;
        cyc(12);
        chk(32'({poe, fl}), 32'h0b);
        uv_det <= 1'b0;
        cyc(12);
        pair_cycle(1'b1, 1'b1);
        chk(32'({poe, fl}), 32'hff);
        tally_and_finish();
    end

endmodule

`default_nettype wire
